// File: core/aisp_regs.svh
// constants of the two-wire converter slave port: addresses, field positions, codes
// assumes inclusion by bare name from the package or the top module
`ifndef AISP_REGS_SVH
`define AISP_REGS_SVH

// =====================================================================
// bus addressing
`define AISP_GLOBAL_ADDR 7'h77
`define AISP_ADDR_W 7

// =====================================================================
// channel select word fields
`define AISP_PRE_HI 7
`define AISP_PRE_LO 5
`define AISP_PRE_LOAD 3'h5
`define AISP_SGL_BIT 4
`define AISP_ODD_BIT 3
`define AISP_CHA_HI 2
`define AISP_CHA_LO 0
`define AISP_SEL_RST 5'h00
`define AISP_COM_CH 5'h10

// =====================================================================
// result word coding
`define AISP_FS_POS 18'sh10000
`define AISP_FS_NEG -18'sh10000
`define AISP_CODE_OVER 18'h30000
`define AISP_CODE_UNDER 18'h0FFFF
`define AISP_CODE_MID 18'h20000
`define AISP_TAIL_ZERO 6'h00
`define AISP_RES_RST 24'h000000

// =====================================================================
// link timing
`define AISP_FAST_BIT_NS 2500
`define AISP_MCLK_NS 25
`define AISP_FAST_BIT_CYC (`AISP_FAST_BIT_NS / `AISP_MCLK_NS)

`endif

// File: core/aisp_pkg.sv
// types shared by the converter slave port
// assumes the constant header sits beside it
package aisp_pkg;
  `include "aisp_regs.svh"

  typedef enum logic [1:0] {
    AISP_PH_ADDR = 2'b00,
    AISP_PH_WRITE = 2'b01,
    AISP_PH_READ = 2'b10,
    AISP_PH_IGNORE = 2'b11
  } aisp_phase_t;

  typedef logic [23:0] aisp_result_t;
  typedef logic [4:0] aisp_chan_t;
endpackage

// File: core/aisp_top.sv
// two-wire slave port of a multichannel converter: start/stop detection, address match,
// result read-out and channel word write, with conversion handshake to the converter core
// assumes scl_clk is the bus clock pin routed as a clock, sda is open drain with pull-up,
// and the converter core runs on mclk and pulses conv_done when a conversion ends
//
// Notes on behaviour
// - data line only pulled low or released
// - works up to 400 kbit/s bus rate
// - addressed slave only; clock is input
// - start and stop detected; busy between
// - repeated start restarts framing, bus stays busy
// - eight data bits then one acknowledge bit
// - ack pulls low, nak releases line
// - data changes only while clock low
// - selected on own or global address match
// - nak address while conversion runs
// - 24-bit result and 8-bit channel word
// - three bytes read start new conversion
// - result bits shifted on falling clock
// - first bit sign, then result msb
// - top two bits encode input range
// - sixteen two's complement bits, six zeros
// - clamp over and under range codes
// - reset selects channel pair zero, converts
// - preamble 000/100 keeps old selection
// - preamble 101 loads five select bits
// - differential pairs or single ended to common
// - stop at read ack aborts, converts
// - also answer the global address
// - stop after write or partial read converts
`timescale 1ns/100ps

module aisp_top
  import aisp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [6:0] own_addr,
  input wire logic conv_done,
  input wire logic signed [17:0] conv_value,
  output logic conv_start,
  output logic conv_busy,
  output aisp_pkg::aisp_chan_t mux_pos_sel,
  output aisp_pkg::aisp_chan_t mux_neg_sel
);
  import aisp_pkg::*;

  // =====================================================================
  // reset release
  logic rst_a_ff, rst_b_ff, rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end

  assign rst_sync_n = rst_b_ff;

  // =====================================================================
  // pin synchronisers and start/stop detection on mclk
  // 40 MHz gives about 100 samples per bit at 400 kbit/s, ample margin
  logic scl_m1_ff, scl_m2_ff, scl_m3_ff;
  logic sda_m1_ff, sda_m2_ff, sda_m3_ff;
  logic [6:0] addr_m1_ff, addr_m2_ff;
  logic start_det, stop_det;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      scl_m1_ff <= 1'b1;
      scl_m2_ff <= 1'b1;
      scl_m3_ff <= 1'b1;
      sda_m1_ff <= 1'b1;
      sda_m2_ff <= 1'b1;
      sda_m3_ff <= 1'b1;
      addr_m1_ff <= 7'h00;
      addr_m2_ff <= 7'h00;
    end
    else
    begin
      scl_m1_ff <= scl_clk;
      scl_m2_ff <= scl_m1_ff;
      scl_m3_ff <= scl_m2_ff;
      sda_m1_ff <= sda_i;
      sda_m2_ff <= sda_m1_ff;
      sda_m3_ff <= sda_m2_ff;
      addr_m1_ff <= own_addr;
      addr_m2_ff <= addr_m1_ff;
    end
  end

  assign start_det = scl_m2_ff & scl_m3_ff & sda_m3_ff & ~sda_m2_ff;
  assign stop_det = scl_m2_ff & scl_m3_ff & ~sda_m3_ff & sda_m2_ff;

  // =====================================================================
  // framing reset for the link logic
  // held while the bus is free and from each start until scl falls; the release
  // lands long before the next rising scl edge, so no edge is lost to it
  logic bus_idle_ff, link_rst_n_ff;
  logic nxt_bus_idle, nxt_link_rst_n;

  assign nxt_bus_idle = stop_det | (bus_idle_ff & ~start_det);
  assign nxt_link_rst_n = ~nxt_bus_idle & ~start_det & (link_rst_n_ff | ~scl_m2_ff);

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      bus_idle_ff <= 1'b1;
      link_rst_n_ff <= 1'b0;
    end
    else
    begin
      bus_idle_ff <= nxt_bus_idle;
      link_rst_n_ff <= nxt_link_rst_n;
    end
  end

  // =====================================================================
  // link logic on the bus clock
  aisp_phase_t phase_ff, nxt_phase;
  logic [3:0] bit_cnt_ff;
  logic [6:0] sh_ff;
  logic [1:0] nbytes_ff;
  logic ack_ff, rw_ff, sda_oe_ff;
  aisp_result_t tx_ff, result_ff;
  logic busy_s1_ff, busy_s2_ff;
  logic wr_tgl_ff, rds_tgl_ff, rdd_tgl_ff;
  logic [7:0] wr_byte_ff;

  logic [7:0] byte_in;
  logic last_bit, ack_slot, addr_hit, nxt_ack;
  logic rd_acked, rd_last;

  assign byte_in = {sh_ff, sda_i};
  assign last_bit = (bit_cnt_ff == 4'd7);
  assign ack_slot = (bit_cnt_ff == 4'd8);
  assign addr_hit = (byte_in[7:1] == addr_m2_ff) | (byte_in[7:1] == `AISP_GLOBAL_ADDR);
  assign rd_acked = (phase_ff == AISP_PH_ADDR) & ack_slot & ack_ff & rw_ff;
  assign rd_last = (phase_ff == AISP_PH_READ) & last_bit & (nbytes_ff == 2'd2);

  assign nxt_ack = (phase_ff == AISP_PH_ADDR) ? (addr_hit & ~busy_s2_ff) :
                   (phase_ff == AISP_PH_WRITE);

  always_comb
  begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      AISP_PH_ADDR: nxt_phase = !ack_ff ? AISP_PH_IGNORE :
                               (rw_ff ? AISP_PH_READ : AISP_PH_WRITE);
      AISP_PH_WRITE: nxt_phase = AISP_PH_IGNORE;
      AISP_PH_READ: nxt_phase = (sda_i || nbytes_ff == 2'd3) ? AISP_PH_IGNORE :
                               AISP_PH_READ;
      AISP_PH_IGNORE: nxt_phase = AISP_PH_IGNORE;
    endcase
  end

  always_ff @(posedge scl_clk or negedge link_rst_n_ff)
  begin
    if (!link_rst_n_ff)
    begin
      phase_ff <= AISP_PH_ADDR;
      bit_cnt_ff <= 4'd0;
      sh_ff <= 7'h00;
    end
    else if (ack_slot)
    begin
      phase_ff <= nxt_phase;
      bit_cnt_ff <= 4'd0;
    end
    else
    begin
      bit_cnt_ff <= bit_cnt_ff + 4'd1;
      sh_ff <= byte_in[6:0];
    end
  end

  always_ff @(posedge scl_clk or negedge link_rst_n_ff)
  begin
    if (!link_rst_n_ff)
    begin
      ack_ff <= 1'b0;
      rw_ff <= 1'b0;
      nbytes_ff <= 2'd0;
    end
    else if (last_bit)
    begin
      ack_ff <= nxt_ack;
      rw_ff <= (phase_ff == AISP_PH_ADDR) ? byte_in[0] : rw_ff;
      nbytes_ff <= (phase_ff == AISP_PH_READ) ? nbytes_ff + 2'd1 : nbytes_ff;
    end
  end

  // result shifter: loaded when a read address is acknowledged
  always_ff @(posedge scl_clk or negedge link_rst_n_ff)
  begin
    if (!link_rst_n_ff)
      tx_ff <= `AISP_RES_RST;
    else if (rd_acked)
      tx_ff <= result_ff;
    else if (phase_ff == AISP_PH_READ && !ack_slot)
      tx_ff <= {tx_ff[22:0], 1'b0};
  end

  // the line is only ever pulled low; a one is sent by releasing it
  always_ff @(negedge scl_clk or negedge link_rst_n_ff)
  begin
    if (!link_rst_n_ff)
      sda_oe_ff <= 1'b0;
    else if (ack_slot)
      sda_oe_ff <= ack_ff;
    else
      sda_oe_ff <= (phase_ff == AISP_PH_READ) & ~tx_ff[23];
  end

  // events toward mclk survive the framing reset, so they use the system reset
  always_ff @(posedge scl_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      busy_s1_ff <= 1'b1;
      busy_s2_ff <= 1'b1;
      wr_tgl_ff <= 1'b0;
      rds_tgl_ff <= 1'b0;
      rdd_tgl_ff <= 1'b0;
      wr_byte_ff <= 8'h00;
    end
    else
    begin
      busy_s1_ff <= conv_busy;
      busy_s2_ff <= busy_s1_ff;
      if ((phase_ff == AISP_PH_WRITE) && last_bit && link_rst_n_ff)
      begin
        wr_tgl_ff <= ~wr_tgl_ff;
        wr_byte_ff <= byte_in;
      end
      if (rd_acked && link_rst_n_ff)
        rds_tgl_ff <= ~rds_tgl_ff;
      if (rd_last && link_rst_n_ff)
        rdd_tgl_ff <= ~rdd_tgl_ff;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_ff;

  // =====================================================================
  // event crossing into mclk
  logic wr_t1_ff, wr_t2_ff, wr_t3_ff;
  logic rds_t1_ff, rds_t2_ff, rds_t3_ff;
  logic rdd_t1_ff, rdd_t2_ff, rdd_t3_ff;
  logic wr_evt, rds_evt, rdd_evt;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      {wr_t1_ff, wr_t2_ff, wr_t3_ff} <= 3'h0;
      {rds_t1_ff, rds_t2_ff, rds_t3_ff} <= 3'h0;
      {rdd_t1_ff, rdd_t2_ff, rdd_t3_ff} <= 3'h0;
    end
    else
    begin
      {wr_t1_ff, wr_t2_ff, wr_t3_ff} <= {wr_tgl_ff, wr_t1_ff, wr_t2_ff};
      {rds_t1_ff, rds_t2_ff, rds_t3_ff} <= {rds_tgl_ff, rds_t1_ff, rds_t2_ff};
      {rdd_t1_ff, rdd_t2_ff, rdd_t3_ff} <= {rdd_tgl_ff, rdd_t1_ff, rdd_t2_ff};
    end
  end

  assign wr_evt = wr_t2_ff ^ wr_t3_ff;
  assign rds_evt = rds_t2_ff ^ rds_t3_ff;
  assign rdd_evt = rdd_t2_ff ^ rdd_t3_ff;

  // =====================================================================
  // conversion control and channel selection
  // the written byte is stable for many mclk cycles around its toggle
  logic init_ff, pend_ff, busy_ff, conv_start_ff;
  aisp_chan_t sel_ff, pos_ff, neg_ff;
  logic start_conv, sel_load;
  aisp_chan_t pos_dec, neg_dec;

  assign start_conv = init_ff | rdd_evt | (stop_det & pend_ff);
  assign sel_load = wr_evt & (wr_byte_ff[`AISP_PRE_HI:`AISP_PRE_LO] == `AISP_PRE_LOAD);
  assign pos_dec = {1'b0, sel_ff[`AISP_CHA_HI:`AISP_CHA_LO], sel_ff[`AISP_ODD_BIT]};
  assign neg_dec = sel_ff[`AISP_SGL_BIT] ? `AISP_COM_CH :
                   {1'b0, sel_ff[`AISP_CHA_HI:`AISP_CHA_LO], ~sel_ff[`AISP_ODD_BIT]};

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      init_ff <= 1'b1;
      pend_ff <= 1'b0;
      busy_ff <= 1'b1;
      conv_start_ff <= 1'b0;
    end
    else
    begin
      init_ff <= 1'b0;
      pend_ff <= wr_evt | rds_evt | (pend_ff & ~start_conv);
      busy_ff <= start_conv | (busy_ff & ~conv_done);
      conv_start_ff <= start_conv;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sel_ff <= `AISP_SEL_RST;
      pos_ff <= 5'h00;
      neg_ff <= 5'h01;
    end
    else
    begin
      if (sel_load)
        sel_ff <= wr_byte_ff[`AISP_SGL_BIT:0];
      if (start_conv)
      begin
        pos_ff <= pos_dec;
        neg_ff <= neg_dec;
      end
    end
  end

  // =====================================================================
  // result coding: value in lsb units, full scale at 2^16
  logic over_rng, under_rng;
  logic [17:0] code18;

  assign over_rng = (conv_value >= `AISP_FS_POS);
  assign under_rng = (conv_value < `AISP_FS_NEG);
  assign code18 = over_rng ? `AISP_CODE_OVER :
                  under_rng ? `AISP_CODE_UNDER :
                  18'(conv_value) + `AISP_CODE_MID;

  // only changes while busy, so the link never loads a half-written word
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      result_ff <= `AISP_RES_RST;
    else if (conv_done && busy_ff)
      result_ff <= {code18, `AISP_TAIL_ZERO};
  end

  assign conv_start = conv_start_ff;
  assign conv_busy = busy_ff;
  assign mux_pos_sel = pos_ff;
  assign mux_neg_sel = neg_ff;

endmodule

// File: sim/aisp_top_monitor.sv
// pin-level checks of the converter slave port
// assumes rst_n is the only reset and mclk samples every watched pin
`timescale 1ns/100ps

module aisp_top_monitor
  import aisp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire aisp_pkg::aisp_chan_t mux_pos_sel,
  input wire aisp_pkg::aisp_chan_t mux_neg_sel
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==========
  // data line
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data driven high");
  ack_edge_a: assert property ($rose(sda_oe) |-> !scl_clk)
    else $error("data moved, clock high");
  busy_quiet_a: assert property ($rose(sda_oe) |-> !conv_busy)
    else $error("answer while busy");

  // ==========
  // conversion handshake
  start_once_a: assert property (conv_start |=> !conv_start)
    else $error("long start pulse");
  done_idle_a: assert property (conv_done && conv_busy |=> !conv_busy || conv_start)
    else $error("busy after done");
  busy_rise_a: assert property ($rose(conv_busy) |-> conv_start)
    else $error("busy without start");
  mux_move_a: assert property ($changed({mux_pos_sel, mux_neg_sel}) |-> conv_start)
    else $error("selection moved");
  mux_pair_a: assert property (!mux_pos_sel[4] &&
    (mux_neg_sel == 5'h10 || (mux_pos_sel ^ mux_neg_sel) == 5'h01))
    else $error("bad channel pair");

  cover property ($rose(sda_oe));
  cover property (conv_done && conv_busy);
  cover property ($changed(mux_neg_sel));
endmodule

bind aisp_top aisp_top_monitor mon (.mclk(mclk), .rst_n(rst_n), .scl_clk(scl_clk),
  .sda_o(sda_o), .sda_oe(sda_oe), .conv_done(conv_done), .conv_start(conv_start),
  .conv_busy(conv_busy), .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel));

// File: sim/aisp_master_model.sv
// two-wire bus master stand-in: start, stop, bits and bytes
// assumes the bench resolves the data line from all pull-downs and a pull-up
`timescale 1ns/100ps

module aisp_master_model (
  output logic scl_clk = 1'b1,
  output logic pull = 1'b0,
  input wire logic sda_i
);
  // quarter bit in 15 ns steps: 2.52 us a bit stays inside fast mode
  localparam int Q = 42 * 15;

  // ==========
  // framing; from a low clock this is a repeated start
  task automatic start();
    pull = 1'b0;
    #Q scl_clk = 1'b1;
    #Q pull = 1'b1;
    #Q scl_clk = 1'b0;
    #Q;
  endtask

  task automatic stop();
    pull = 1'b1;
    #Q scl_clk = 1'b1;
    #Q pull = 1'b0;
    #(2 * Q);
  endtask

  // ==========
  // data: only ever pulls low, changes only with the clock low
  task automatic xbit(input logic b, output logic r);
    pull = ~b;
    #Q scl_clk = 1'b1;
    #Q r = sda_i;
    #Q scl_clk = 1'b0;
    #Q;
  endtask

  task automatic xbyte(input logic [7:0] w, input logic mack, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(w[i], r);
      q[i] = r;
    end
    xbit(~mack, r);
    ack = ~r;
  endtask
endmodule

// File: sim/aisp_top_test.sv
// bench of the converter slave port with a bus master model and a converter stand-in
// assumes the master model and the bound monitor are compiled before it
`timescale 1ns/100ps

module aisp_top_test;
  import aisp_pkg::*;
  localparam int CONV = 1200;
  logic mclk = 1'b0, rst_n = 1'b0, conv_done = 1'b0;
  logic scl, pull, sda_o, sda_oe, conv_start, conv_busy, ack;
  logic signed [17:0] conv_value = '0;
  logic [6:0] own = 7'h00;
  logic [7:0] d;
  logic [9:0] got_sel;
  aisp_chan_t mux_pos_sel, mux_neg_sel, ep = 5'h00, en = 5'h01;
  int n_mismatch = 0, n_checks = 0, seed = 41, cnt = 0, n_start = 0, n0;
  logic [7:0] wtab [5] = '{8'h00, 8'h9F, 8'hB0, 8'hAF, 8'hBF};
  logic [2:0] ptab [3] = '{3'h0, 3'h4, 3'h5};
  logic [17:0] vtab [6] = '{18'h3FFFF, 18'h0FFFF, 18'h30000, 18'h10000,
    18'h11170, 18'h2EE90};
  wire logic sda = ~((sda_oe & ~sda_o) | pull);

  always #12.5 mclk = ~mclk;

  aisp_top dut (.mclk(mclk), .rst_n(rst_n), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .own_addr(own), .conv_done(conv_done), .conv_value(conv_value),
    .conv_start(conv_start), .conv_busy(conv_busy), .mux_pos_sel(mux_pos_sel),
    .mux_neg_sel(mux_neg_sel));
  aisp_master_model m (.scl_clk(scl), .pull(pull), .sda_i(sda));

  // ==========
  // converter stand-in; its long fixed time leaves room for a refused read or write address
  always @(posedge mclk)
  begin
    conv_done <= #1 (cnt == 1);
    cnt <= conv_start ? CONV : (cnt > 0 ? cnt - 1 : 0);
  end

  always @(negedge mclk)
    if (conv_start === 1'b1)
    begin
      n_start++;
      got_sel = {mux_pos_sel, mux_neg_sel};
    end

  // ==========
  // expectations
  function automatic logic [23:0] exp_res(input logic signed [17:0] v);
    if (v < -18'sh10000)
      return 24'h3FFFC0;
    return {(v > 18'sh10000 ? 18'sh10000 : v) + 18'sh20000, 6'h00};
  endfunction

  function automatic logic [9:0] exp_sel(input logic [7:0] w, input logic [9:0] old);
    if (w[7:5] != 3'h5)
      return old;
    return {1'b0, w[2:0], w[3], w[4] ? 5'h10 : {1'b0, w[2:0], ~w[3]}};
  endfunction

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    n_mismatch += int'(got !== exp);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========
  // bounded waits and bus sequences
  task automatic wait_conv(input int from);
    int i;
    for (i = 0; i < 400 && n_start == from; i++)
      @(negedge mclk);
    check(24'(n_start - from), 24'h1);
    if (i == 400)
      report_and_stop();
    check(24'(got_sel), 24'({ep, en}));
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000 && conv_busy !== 1'b0; i++)
      @(negedge mclk);
    check(24'(i == 2000), 24'h0);
    if (i == 2000)
      report_and_stop();
  endtask

  task automatic addr(input logic [6:0] a, input logic rw, input logic exp);
    m.start();
    m.xbyte({a, rw}, 1'b0, d, ack);
    check(24'(ack), 24'(exp));
  endtask

  task automatic write_word(input logic [7:0] w);
    n0 = n_start;
    addr(own, 1'b0, 1'b1);
    m.xbyte(w, 1'b0, d, ack);
    check(24'(ack), 24'h1);
    m.stop();
    {ep, en} = exp_sel(w, {ep, en});
    wait_conv(n0);
    wait_idle();
  endtask

  task automatic read3(input logic [6:0] a);
    logic [23:0] rd;
    n0 = n_start;
    addr(a, 1'b1, 1'b1);
    for (int k = 2; k >= 0; k--)
    begin
      m.xbyte(8'hFF, k != 0, d, ack);
      rd[k * 8 +: 8] = d;
    end
    check(rd, exp_res(conv_value));
    wait_conv(n0);
  endtask

  initial
  begin
    own = {1'b0, 6'($random(seed))};
    repeat (8) @(posedge mclk);
    rst_n <= #1 1'b1;
    wait_conv(0);
    addr(own, 1'b1, 1'b0);
    m.stop();
    wait_idle();
    n0 = n_start;
    addr(own ^ 7'h01, 1'b0, 1'b0);
    m.xbyte(8'hBF, 1'b0, d, ack);
    m.stop();
    repeat (100) @(negedge mclk);
    check(24'(n_start - n0), 24'h0);
    for (int k = 0; k < 9; k++)
      write_word(k < 5 ? wtab[k] : {ptab[$unsigned($random(seed)) % 3], 5'($random(seed))});
    for (int k = 0; k < 8; k++)
    begin
      read3(k[0] ? 7'h77 : own);
      @(posedge mclk);
      conv_value <= #1 (k < 6 ? vtab[k] : 18'($random(seed)));
      addr(own, k[1], 1'b0);
      m.stop();
      wait_idle();
    end
    n0 = n_start;
    addr(own, 1'b1, 1'b1);
    for (int i = 7; i >= 0; i--)
      m.xbit(1'b1, d[i]);
    m.stop();
    check(24'(d), exp_res(conv_value) >> 16);
    wait_conv(n0);
    report_and_stop();
  end
endmodule
